//--- hdl/pfb_fifo_top.v
// Parameterised FIFO buffer with AXI4-Lite control and status registers
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "pfb_consts.vh"
module pfb_fifo_top (
    input  wire                   aclk,
    input  wire                   aresetn,
    input  wire [`PFB_ADDR_W-1:0] s_axi_awaddr,
    input  wire                   s_axi_awvalid,
    output wire                   s_axi_awready,
    input  wire [31:0]            s_axi_wdata,
    input  wire [3:0]             s_axi_wstrb,
    input  wire                   s_axi_wvalid,
    output wire                   s_axi_wready,
    output reg  [1:0]             s_axi_bresp,
    output reg                    s_axi_bvalid,
    input  wire                   s_axi_bready,
    input  wire [`PFB_ADDR_W-1:0] s_axi_araddr,
    input  wire                   s_axi_arvalid,
    output wire                   s_axi_arready,
    output reg  [31:0]            s_axi_rdata,
    output reg  [1:0]             s_axi_rresp,
    output reg                    s_axi_rvalid,
    input  wire                   s_axi_rready,
    input  wire                   fifo_clr,
    input  wire                   wr_clk_pin,
    input  wire                   wr_req,
    input  wire [`PFB_DW-1:0]     wr_data,
    output wire                   wr_full,
    output wire                   wr_empty,
    output wire [`PFB_AW:0]       wr_fill,
    input  wire                   rd_clk_pin,
    input  wire                   rd_req,
    output wire [`PFB_DW-1:0]     rd_data,
    output wire                   rd_full,
    output wire                   rd_empty,
    output wire [`PFB_AW:0]       rd_fill,
    output wire                   near_full,
    output wire                   near_empty
);
    localparam AW = `PFB_AW;
    localparam DW = `PFB_DW;

    reg  [31:0]   ctrl_q;
    reg  [31:0]   thr_q;
    reg  [DW-1:0] mem [0:`PFB_DEPTH-1];
    reg  [AW:0]   wptr_q;
    reg  [AW:0]   wgray_q;
    reg  [AW:0]   rptr_q;
    reg  [AW:0]   rgray_q;
    reg  [DW-1:0] out_q;
    reg  [DW-1:0] oreg_q;
    reg           wclr_q;
    reg           rclr_q;
    reg           aw_hold_q;
    reg           w_hold_q;
    reg  [`PFB_ADDR_W-1:0] awaddr_q;
    reg  [31:0]   wdata_q;
    reg  [3:0]    wstrb_q;
    wire          wck_s;
    wire          wck_d;
    wire          rck_s;
    wire          rck_d;
    wire [DW:0]   wbus_s;
    wire          rreq_s;
    wire          clr_s;
    wire [AW:0]   wgray_at_r;
    wire [AW:0]   rgray_at_w;
    wire [31:0]   strb_m;
    wire [31:0]   status_w;
    wire [31:0]   fill_w;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    wire dual    = ctrl_q[`PFB_CTRL_DUAL];
    wire look    = ctrl_q[`PFB_CTRL_LOOK];
    wire wguard  = ctrl_q[`PFB_CTRL_WGUARD];
    wire rguard  = ctrl_q[`PFB_CTRL_RGUARD];
    wire extra   = ctrl_q[`PFB_CTRL_EXTRA] & dual; // R7
    wire csyncw  = ctrl_q[`PFB_CTRL_CSYNCW];
    wire csyncr  = ctrl_q[`PFB_CTRL_CSYNCR];
    wire oreg_en = ctrl_q[`PFB_CTRL_OREG];
    wire related = ctrl_q[`PFB_CTRL_RELATED] & dual;
    wire [AW:0] nf_thr = thr_q[AW:0];
    wire [AW:0] ne_thr = thr_q[8+AW:8];

    // Gray to binary for pointers arriving from the other side
    function [AW:0] g2b;
        input [AW:0] g;
        integer k;
        begin
            g2b[AW] = g[AW];
            for (k = AW - 1; k >= 0; k = k - 1)
                g2b[k] = g2b[k+1] ^ g[k];
        end
    endfunction

    // ------------------------------------------------------------
    // Pin capture
    // ------------------------------------------------------------
    // Both side clocks are pins; their rises become one-cycle ticks
    pfb_pin_sync #(.W(1)) u_wck (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (wr_clk_pin),
        .q       (wck_s),
        .q_dly   (wck_d)
    );

    pfb_pin_sync #(.W(1)) u_rck (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (rd_clk_pin),
        .q       (rck_s),
        .q_dly   (rck_d)
    );

    // Request and data are taken from the delayed stage so they match
    // the level seen just before the clock pin rose
    pfb_pin_sync #(.W(DW+1)) u_wbus (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({wr_req, wr_data}),
        .q       (),
        .q_dly   (wbus_s)
    );

    pfb_pin_sync #(.W(1)) u_rreq (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (rd_req),
        .q       (),
        .q_dly   (rreq_s)
    );

    pfb_pin_sync #(.W(1)) u_clr (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (fifo_clr),
        .q       (clr_s),
        .q_dly   ()
    );

    wire wr_tick = wck_s & ~wck_d; // R16
    // Single-clock variant runs the read side from the write clock
    wire rd_tick = dual ? (rck_s & ~rck_d) : wr_tick; // R15 R16

    // ------------------------------------------------------------
    // Clear handling
    // ------------------------------------------------------------
    // Clear asserts at once; when synchronised it releases only on
    // a side's own clock edge, so no request races the release
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wclr_q <= 1'b0;
            rclr_q <= 1'b0;
        end
        else
        begin
            if (clr_s)
                wclr_q <= 1'b1;
            else if (wr_tick)
                wclr_q <= 1'b0; // R10
            if (clr_s)
                rclr_q <= 1'b1;
            else if (rd_tick)
                rclr_q <= 1'b0; // R11
        end
    end

    wire wr_clr = clr_s | (csyncw & wclr_q); // R10 R20
    wire rd_clr = clr_s | (csyncr & rclr_q); // R11 R20

    // ------------------------------------------------------------
    // Pointer crossing
    // ------------------------------------------------------------
    pfb_ptr_sync #(.W(AW+1), .STAGES(`PFB_SYNC_W2R)) u_w2r (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .en        (rd_tick),
        .clr       (rd_clr),
        .short_sel (related),
        .d         (wgray_q),
        .q         (wgray_at_r)
    );

    pfb_ptr_sync #(.W(AW+1), .STAGES(`PFB_SYNC_R2W)) u_r2w (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .en        (wr_tick),
        .clr       (wr_clr),
        .short_sel (related),
        .d         (rgray_q),
        .q         (rgray_at_w)
    );

    // One clock needs no crossing; dual clocks use the Gray copies
    wire [AW:0] rptr_at_w = dual ? g2b(rgray_at_w) : rptr_q; // R8 R19
    wire [AW:0] wptr_at_r = dual ? g2b(wgray_at_r) : wptr_q; // R8 R19

    // ------------------------------------------------------------
    // Counts and flags
    // ------------------------------------------------------------
    // Depth is a power of two, so the count top bit marks full
    wire [AW:0] wcnt = wptr_q - rptr_at_w; // R2
    wire [AW:0] rcnt = wptr_at_r - rptr_q;

    assign wr_full    = wcnt[AW]; // R18
    assign wr_empty   = (wcnt == {(AW+1){1'b0}});
    assign rd_full    = rcnt[AW];
    assign rd_empty   = (rcnt == {(AW+1){1'b0}}); // R18
    // Without the extra bit a full buffer wraps to zero
    assign wr_fill    = extra ? wcnt : {1'b0, wcnt[AW-1:0]}; // R1 R7
    assign rd_fill    = extra ? rcnt : {1'b0, rcnt[AW-1:0]}; // R1 R7
    assign near_full  = (wcnt >= nf_thr); // R13
    assign near_empty = (rcnt < ne_thr); // R14

    // ------------------------------------------------------------
    // Write side
    // ------------------------------------------------------------
    // Unguarded writes to a full buffer overwrite unread words
    wire wr_do = wr_tick & wbus_s[DW] & ~wr_clr & ~(wguard & wr_full); // R5 R17
    wire [AW:0] wptr_n = wptr_q + 1'b1;

    always @(posedge aclk)
    begin
        if (wr_do)
            mem[wptr_q[AW-1:0]] <= wbus_s[DW-1:0];
    end

    always @(posedge aclk)
    begin
        if (!aresetn || wr_clr)
        begin
            wptr_q  <= {(AW+1){1'b0}}; // R20
            wgray_q <= {(AW+1){1'b0}};
        end
        else if (wr_do)
        begin
            wptr_q  <= wptr_n;
            wgray_q <= wptr_n ^ (wptr_n >> 1); // R19
        end
    end

    // ------------------------------------------------------------
    // Read side
    // ------------------------------------------------------------
    // Unguarded reads from empty advance past valid data
    wire rd_do = rd_tick & rreq_s & ~rd_clr & ~(rguard & rd_empty); // R6
    wire [AW:0] rptr_n = rptr_q + 1'b1;
    wire [AW:0] rptr_nx = rd_do ? rptr_n : rptr_q;

    always @(posedge aclk)
    begin
        if (!aresetn || rd_clr)
        begin
            rptr_q  <= {(AW+1){1'b0}}; // R20
            rgray_q <= {(AW+1){1'b0}};
        end
        else if (rd_do)
        begin
            rptr_q  <= rptr_n;
            rgray_q <= rptr_n ^ (rptr_n >> 1); // R19
        end
    end

    // Lookahead keeps the head word on show; normal mode loads on read
    always @(posedge aclk)
    begin
        if (!aresetn || rd_clr)
            out_q <= {DW{1'b0}};
        else if (look)
            out_q <= mem[rptr_nx[AW-1:0]]; // R4
        else if (rd_do)
            out_q <= mem[rptr_q[AW-1:0]]; // R3
    end

    // Optional extra stage on the read clock trades latency for speed
    always @(posedge aclk)
    begin
        if (!aresetn || rd_clr)
            oreg_q <= {DW{1'b0}};
        else if (rd_tick)
            oreg_q <= out_q; // R12
    end

    assign rd_data = oreg_en ? oreg_q : out_q; // R12

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_hold_q & ~s_axi_bvalid;
    assign strb_m = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

    // Address and data may arrive in either order; answer after both
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
            awaddr_q     <= {`PFB_ADDR_W{1'b0}};
            wdata_q      <= 32'h0000_0000;
            wstrb_q      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `PFB_RESP_OKAY;
            ctrl_q       <= `PFB_CTRL_RST; // R9
            thr_q        <= `PFB_THR_RST;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (aw_hold_q && w_hold_q)
            begin
                aw_hold_q    <= 1'b0;
                w_hold_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `PFB_RESP_OKAY;
                if (awaddr_q == `PFB_OFS_CTRL)
                    ctrl_q <= ((ctrl_q & ~strb_m) | (wdata_q & strb_m)) & `PFB_CTRL_MASK; // R15
                else if (awaddr_q == `PFB_OFS_THRESH)
                    thr_q <= ((thr_q & ~strb_m) | (wdata_q & strb_m)) & `PFB_THR_MASK;
                else if (awaddr_q != `PFB_OFS_STATUS && awaddr_q != `PFB_OFS_FILL)
                    s_axi_bresp <= `PFB_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    assign s_axi_arready = ~s_axi_rvalid;
    assign status_w = {26'h000_0000, near_empty, near_full, rd_empty, rd_full, wr_empty, wr_full};
    assign fill_w   = {19'h0_0000, rd_fill, 3'h0, wr_fill};

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `PFB_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `PFB_RESP_OKAY;
            if (s_axi_araddr == `PFB_OFS_CTRL)
                s_axi_rdata <= ctrl_q;
            else if (s_axi_araddr == `PFB_OFS_THRESH)
                s_axi_rdata <= thr_q;
            else if (s_axi_araddr == `PFB_OFS_STATUS)
                s_axi_rdata <= status_w;
            else if (s_axi_araddr == `PFB_OFS_FILL)
                s_axi_rdata <= fill_w;
            else
            begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `PFB_RESP_SLVERR;
            end
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule // pfb_fifo_top

//--- include/pfb_consts.vh
// Constants for the parameterised FIFO buffer block and its register map
// Notes on behaviour
// R1: Fill-level outputs take their width from the fill-count width setting.
// R2: Depth is at least four words and equals two to the fill-count width.
// R3: Normal read mode moves a new word out only on a read request.
// R4: Lookahead mode shows the first word unasked; a read request advances it.
// R5: With the write guard on, writes to a full buffer are ignored.
// R6: With the read guard on, reads from an empty buffer are ignored.
// R7: Extra fill bit widens both fill levels so full reports its true count. Here it acts only in the dual-clock variant and is ignored in single-clock.
// R8: Cross-side pointer state passes through configured synchroniser stage counts.
// R9: Related-clocks flag defaults false; only locked integer-multiple clocks may set it.
// R10: Optional clear synchronisation to the write clock removes clear/write race.
// R11: Optional clear synchronisation to the read clock removes clear/read race.
// R12: Output register option adds one pipeline stage to the read word.
// R13: Near-full is high when stored count is at or above its threshold.
// R14: Near-empty is high when stored count is below its threshold.
// R15: Variant setting selects single-clock or independent dual-clock operation.
// R16: Write-side ports follow the write clock, read-side ports the read clock.
// R17: Writer never requests while full or while the clear is released.
// R18: Writer judges by write-side full, reader by read-side empty.
// R19: Pointers cross between the clock sides in Gray code.
// R20: Clear empties the buffer, zeroes pointers and fills, drops full flags.
`ifndef PFB_CONSTS_VH
`define PFB_CONSTS_VH

// ----------------------------------------------------------------
// Storage geometry
// ----------------------------------------------------------------
`define PFB_DW          8
`define PFB_AW          4
`define PFB_DEPTH       16
`define PFB_SYNC_W2R    3
`define PFB_SYNC_R2W    3
`define PFB_SYNC_SHORT  2

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define PFB_ADDR_W      4
`define PFB_OFS_CTRL    4'h0
`define PFB_OFS_THRESH  4'h4
`define PFB_OFS_STATUS  4'h8
`define PFB_OFS_FILL    4'hC

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define PFB_CTRL_DUAL    0
`define PFB_CTRL_LOOK    1
`define PFB_CTRL_WGUARD  2
`define PFB_CTRL_RGUARD  3
`define PFB_CTRL_EXTRA   4
`define PFB_CTRL_CSYNCW  5
`define PFB_CTRL_CSYNCR  6
`define PFB_CTRL_OREG    7
`define PFB_CTRL_RELATED 8
`define PFB_CTRL_MASK    32'h0000_01FF
`define PFB_CTRL_RST     32'h0000_000C
`define PFB_THR_MASK     32'h0000_1F1F
`define PFB_THR_RST      32'h0000_020E
`define PFB_RESP_OKAY    2'h0
`define PFB_RESP_SLVERR  2'h2

`endif

//--- hdl/pfb_pin_sync.v
// Two-flop pin synchroniser with one extra delayed stage
`timescale 1ns/1ps
module pfb_pin_sync #(
    parameter W = 1
) (
    input  wire         aclk,
    input  wire         aresetn,
    input  wire [W-1:0] d,
    output wire [W-1:0] q,
    output wire [W-1:0] q_dly
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;

    // ------------------------------------------------------------
    // Capture chain
    // ------------------------------------------------------------
    // Stage three holds the value sampled just before a pin rise
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
            s3_q <= {W{1'b0}};
        end
        else
        begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign q     = s2_q;
    assign q_dly = s3_q;
endmodule // pfb_pin_sync

//--- hdl/pfb_ptr_sync.v
// Gray pointer synchroniser stepped by the destination side tick
`timescale 1ns/1ps
`include "pfb_consts.vh"
module pfb_ptr_sync #(
    parameter W      = 5,
    parameter STAGES = 3
) (
    input  wire         aclk,
    input  wire         aresetn,
    input  wire         en,
    input  wire         clr,
    input  wire         short_sel,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] stage_q [0:STAGES-1];
    genvar      i;

    // ------------------------------------------------------------
    // Stage chain
    // ------------------------------------------------------------
    // Stages step on destination ticks, as a real crossing would
    generate
        for (i = 0; i < STAGES; i = i + 1)
        begin : g_stage
            always @(posedge aclk)
            begin
                if (!aresetn || clr)
                    stage_q[i] <= {W{1'b0}};
                else if (en)
                    stage_q[i] <= (i == 0) ? d : stage_q[(i == 0) ? 0 : i - 1];
            end
        end
    endgenerate

    // Related clocks take the shorter tap
    assign q = short_sel ? stage_q[`PFB_SYNC_SHORT-1] : stage_q[STAGES-1]; // R9
endmodule // pfb_ptr_sync

//--- sim/pfb_fifo_assertions.sv
// Port checker for the FIFO buffer block
`timescale 1ns/1ps
`include "pfb_consts.vh"
module pfb_fifo_checker (
    input wire              aclk,
    input wire              aresetn,
    input wire              s_axi_awready,
    input wire              s_axi_wready,
    input wire              s_axi_bvalid,
    input wire              s_axi_arvalid,
    input wire              s_axi_arready,
    input wire              s_axi_rvalid,
    input wire              fifo_clr,
    input wire              wr_full,
    input wire              wr_empty,
    input wire [`PFB_AW:0]  wr_fill,
    input wire              rd_empty,
    input wire [`PFB_AW:0]  rd_fill,
    input wire              near_full
);
    // --------
    // Properties
    // --------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    reset_state_a: assert property ($rose(aresetn) |-> wr_empty && rd_empty && !wr_full && !near_full)
        else $error("state after reset wrong");
    clear_empty_a: assert property (fifo_clr [*5] |-> wr_empty && !wr_full && wr_fill == 5'h00)
        else $error("clear did not empty");
    full_count_a: assert property (wr_full |-> wr_fill == 5'h00 || wr_fill == 5'h10)
        else $error("full with odd fill");
    fill_top_a: assert property ($rose(wr_full) |-> $past(wr_fill) == 5'h0F)
        else $error("full rose from wrong fill");
    empty_count_a: assert property (wr_empty |-> wr_fill == 5'h00)
        else $error("write side empty with fill");
    rd_empty_count_a: assert property (rd_empty |-> rd_fill == 5'h00)
        else $error("read side empty with fill");
    first_word_a: assert property ($fell(wr_empty) |-> wr_fill == 5'h01)
        else $error("first write fill wrong");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
endmodule // pfb_fifo_checker

bind pfb_fifo_top pfb_fifo_checker pfb_fifo_checker_inst (.*);

//--- sim/pfb_user_model.sv
// User logic model: link clocks, writer and reader
`timescale 1ns/1ps
`include "pfb_consts.vh"
module pfb_user_model (
    input  wire               aclk,
    input  wire               dual,
    output reg                wr_clk_pin,
    output reg                rd_clk_pin,
    output reg                wr_req,
    output reg  [`PFB_DW-1:0] wr_data,
    output reg                rd_req
);
    wire rck = dual ? rd_clk_pin : wr_clk_pin;

    // Free clocks at 160 ns, phases unrelated to aclk and each other
    initial
    begin
        wr_clk_pin = 1'b0;
        #7;
        forever #80 wr_clk_pin = ~wr_clk_pin;
    end
    initial
    begin
        rd_clk_pin = 1'b0;
        wr_req = 1'b0;
        rd_req = 1'b0;
        wr_data = 8'hA5;
        #43;
        forever #80 rd_clk_pin = ~rd_clk_pin;
    end

    // One write; the task does not check for a full buffer
    task push(input [`PFB_DW-1:0] d);
    begin
        @(negedge wr_clk_pin);
        @(posedge aclk);
        wr_req <= 1'b1;
        wr_data <= d;
        @(negedge wr_clk_pin);
        @(posedge aclk);
        wr_req <= 1'b0;
        wr_data <= ~d;
        repeat (3) @(negedge aclk);
    end
    endtask

    // One read on the side clock in use
    task pop;
    begin
        @(negedge rck);
        @(posedge aclk);
        rd_req <= 1'b1;
        @(negedge rck);
        @(posedge aclk);
        rd_req <= 1'b0;
        repeat (3) @(negedge aclk);
    end
    endtask
endmodule // pfb_user_model

//--- sim/pfb_fifo_top_bench.sv
// Self-checking bench for the FIFO buffer block
`timescale 1ns/1ps
`include "pfb_consts.vh"
module pfb_fifo_top_bench;
    reg                    aclk, aresetn, fifo_clr, dual;
    reg  [`PFB_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    reg  [31:0]            s_axi_wdata, rv;
    reg  [3:0]             s_axi_wstrb;
    reg                    s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    wire                   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]             s_axi_bresp, s_axi_rresp;
    reg  [1:0]             rsp;
    wire [31:0]            s_axi_rdata;
    wire                   wr_clk_pin, rd_clk_pin, wr_req, rd_req;
    wire [`PFB_DW-1:0]     wr_data, rd_data;
    wire                   wr_full, wr_empty, rd_full, rd_empty, near_full, near_empty;
    wire [`PFB_AW:0]       wr_fill, rd_fill;
    integer                errors, compares, i;
    integer                cycles = 0;

    pfb_fifo_top pfb_fifo_top_inst (.*);
    pfb_user_model pfb_user_model_inst (.*);

    // --------
    // Clock, hang guard, helpers
    // --------
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // Ceiling is more than four times the expected run
    always @(posedge aclk)
    begin
        cycles = cycles + 1;
        if (cycles == 6000)
        begin
            errors = errors + 1;
            wrap_up;
        end
    end
    task wrap_up;
    begin
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    task chk(input [31:0] e, input [31:0] s, input [63:0] nm);
    begin
        compares = compares + 1;
        if (s !== e)
        begin
            errors = errors + 1;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    end
    endtask
    // Requests held until taken at a rising edge
    task axi_wr(input [3:0] a, input [31:0] d);
    begin
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    end
    endtask
    task axi_rd(input [3:0] a);
    begin
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        rv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    end
    endtask

    // --------
    // Scenarios
    // --------
    // Reset values, read-only places, control read-back
    task t_regs;
    begin
        axi_rd(`PFB_OFS_CTRL);
        chk(`PFB_CTRL_RST, rv, "ctrl");
        chk(`PFB_RESP_OKAY, rsp, "rresp");
        axi_rd(`PFB_OFS_THRESH);
        chk(`PFB_THR_RST, rv, "thresh");
        axi_rd(`PFB_OFS_STATUS);
        chk(32'h0000_002A, rv, "status");
        axi_wr(`PFB_OFS_FILL, 32'hFFFF_FFFF);
        chk(`PFB_RESP_OKAY, rsp, "bresp");
        axi_rd(`PFB_OFS_FILL);
        chk(32'h0000_0000, rv, "fill");
        axi_wr(`PFB_OFS_CTRL, 32'hFFFF_FFFD);
        axi_rd(`PFB_OFS_CTRL);
        chk(32'h0000_01FD, rv, "ctrl_rw");
        axi_wr(`PFB_OFS_CTRL, `PFB_CTRL_RST);
    end
    endtask
    // Single clock, normal read
    task t_single;
    begin
        for (i = 0; i < 16; i = i + 1)
        begin
            pfb_user_model_inst.push(8'h10 + i[7:0]);
            if (i == 0) chk(1, near_empty, "n_empty");
            if (i == 1) chk(0, near_empty, "n_empty");
            if (i == 12) chk(0, near_full, "n_full");
            if (i == 13) chk(1, near_full, "n_full");
        end
        chk(1, wr_full, "wr_full");
        chk(0, wr_fill, "wr_fill");
        pfb_user_model_inst.push(8'hEE);
        chk(0, rd_data, "rd_idle");
        for (i = 0; i < 16; i = i + 1)
        begin
            pfb_user_model_inst.pop;
            chk(8'h10 + i[7:0], rd_data, "rd_data");
        end
        chk(1, rd_empty, "rd_empty");
        pfb_user_model_inst.pop;
        chk(8'h1F, rd_data, "rd_guard");
        chk(0, rd_fill, "rd_fill");
    end
    endtask
    // Lookahead shows the head word unasked
    task t_look;
    begin
        axi_wr(`PFB_OFS_CTRL, 32'h0000_000E);
        pfb_user_model_inst.push(8'h5A);
        chk(8'h5A, rd_data, "look_hd");
        pfb_user_model_inst.push(8'h5B);
        chk(8'h5A, rd_data, "look_hd");
        pfb_user_model_inst.pop;
        chk(8'h5B, rd_data, "look_nx");
        pfb_user_model_inst.pop;
        chk(1, rd_empty, "rd_empty");
        axi_wr(`PFB_OFS_CTRL, `PFB_CTRL_RST);
    end
    endtask
    // Clear in mid-run empties the buffer
    task t_clear;
    begin
        for (i = 0; i < 3; i = i + 1)
            pfb_user_model_inst.push(8'h21 + i[7:0]);
        @(posedge aclk);
        fifo_clr <= 1'b1;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        chk(1, wr_empty, "clr_emp");
        chk(0, wr_fill, "clr_fill");
        chk(0, rd_data, "clr_data");
        @(posedge aclk);
        fifo_clr <= 1'b0;
        repeat (4) @(posedge aclk);
    end
    endtask
    // Dual clock, extra fill bit
    task t_dual;
    begin
        dual <= 1'b1;
        axi_wr(`PFB_OFS_CTRL, 32'h0000_001D);
        for (i = 0; i < 16; i = i + 1)
            pfb_user_model_inst.push(8'h40 + i[7:0]);
        chk(0, rd_fill == 5'h10, "rd_lag");
        chk(16, wr_fill, "wr_fill");
        repeat (5) @(posedge rd_clk_pin);
        repeat (4) @(negedge aclk);
        chk(16, rd_fill, "rd_fill");
        chk(1, rd_full, "rd_full");
        for (i = 0; i < 16; i = i + 1)
        begin
            pfb_user_model_inst.pop;
            chk(8'h40 + i[7:0], rd_data, "rd_data");
        end
        chk(1, rd_empty, "rd_empty");
    end
    endtask

    // Reset for five cycles, then the scenarios
    initial
    begin
        errors = 0;
        compares = 0;
        dual = 1'b0;
        aresetn = 1'b0;
        fifo_clr = 1'b0;
        s_axi_wstrb = 4'hF;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        t_regs;
        t_single;
        t_look;
        t_clear;
        t_dual;
        wrap_up;
    end
endmodule // pfb_fifo_top_bench
